// [hdl/p7pf_top.sv]
/*
 * Function select for port 7 bits 7, 6 and 5 with its control registers on
 * a classic Wishbone slave.
 * Assumes the timers and three-phase logic sit beside it and that the pads
 * are resolved outside from each pin's active-low output enable.
 */
`timescale 1ns/1ns
module p7pf_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [p7pf_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [p7pf_pkg::DAT_W-1:0] wb_dat_i,
  output logic [p7pf_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic port7_bit7_pin_i,
  output logic port7_bit7_pin_o,
  output logic port7_bit7_pin_oe_n_o,
  output logic port7_bit7_pull_up_o,
  input wire logic port7_bit6_pin_i,
  output logic port7_bit6_pin_o,
  output logic port7_bit6_pin_oe_n_o,
  output logic port7_bit6_pull_up_o,
  input wire logic port7_bit5_pin_i,
  output logic port7_bit5_pin_o,
  output logic port7_bit5_pin_oe_n_o,
  output logic port7_bit5_pull_up_o,
  input wire logic ta3_pulse_i,
  input wire logic w_phase_i,
  output logic timer3_input_pin_o,
  output logic ta3_updown_o,
  output logic ta3_twophase_o,
  output logic timer2_input_pin_o,
  output logic ta3_gate_mode_o,
  output logic ta2_gate_mode_o
);
  import p7pf_pkg::*;

  // -----------------------------------------------------------------------
  // Control registers
  // -----------------------------------------------------------------------
  logic [REG_W-1:0] dir_ff;
  logic [REG_W-1:0] pull_ff;
  logic [REG_W-1:0] trig_ff;
  logic [REG_W-1:0] ta3_mode_ff;
  logic [REG_W-1:0] ta2_mode_ff;
  logic [REG_W-1:0] updn_ff;
  logic [REG_W-1:0] tph_ff;
  logic [REG_W-1:0] data_ff;
  logic ack_ff;
  logic [DAT_W-1:0] rdat_ff;

  // -----------------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------------
  wire logic [IDX_W-1:0] idx = wb_adr_i[ADR_W-1:2];
  wire logic req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire logic wr_go = req & wb_we_i & wb_sel_i[0];
  wire logic [REG_W-1:0] wbyte = wb_dat_i[REG_W-1:0];
  wire logic hit_dir = idx == IDX_DIR;
  wire logic hit_pull = idx == IDX_PULL;
  wire logic hit_trig = idx == IDX_TRIG;
  wire logic hit_ta3 = idx == IDX_TA3_MODE;
  wire logic hit_ta2 = idx == IDX_TA2_MODE;
  wire logic hit_updn = idx == IDX_UPDN;
  wire logic hit_tph = idx == IDX_TPH;
  wire logic hit_data = idx == IDX_DATA;
  wire logic hit_stat = idx == IDX_STAT;

  // -----------------------------------------------------------------------
  // Function decode
  // -----------------------------------------------------------------------
  wire logic tph_on = tph_ff[B_TPH_ENABLE];
  wire logic ta3_pulse_mode = ta3_mode_ff[B_MODE_PULSE];
  wire logic ta3_gate = ta3_mode_ff[B_MODE_GATE];
  wire logic ta3_2ph = updn_ff[B_UPDN_TA3_2PH];
  wire logic trig_ta3_clr = ~trig_ff[B_TRIG_TA3_HI] & ~trig_ff[B_TRIG_TA3_LO];
  wire logic trig_ta2_clr = ~trig_ff[B_TRIG_TA2_HI] & ~trig_ff[B_TRIG_TA2_LO];
  wire logic pull_grp = pull_ff[B_PULL_P74_77];

  // Count source input ignores the gate bit, so the pin feeds the timer
  // whenever it is an input with the trigger select cleared and, for timer 2, three-phase off.
  wire logic sel_ta3_in = ~dir_ff[B_P7] & trig_ta3_clr;
  wire logic sel_ta2_in = ~dir_ff[B_P5] & trig_ta2_clr & ~tph_on;
  wire logic sel_ta3_ud = ~dir_ff[B_P6] & ta3_gate & ~ta3_pulse_mode & ~ta3_2ph;
  wire logic sel_ta3_2ph = ~dir_ff[B_P6] & ta3_gate & ~ta3_pulse_mode & ta3_2ph;
  // The pulse output is withheld during two-phase processing; the pin then
  // falls back to its direction bit rather than floating an undefined drive.
  wire logic sel_ta3_pulse = ta3_pulse_mode & ~ta3_2ph;
  wire logic sel_w = tph_on;

  wire logic drv7 = dir_ff[B_P7];
  wire logic drv6 = sel_ta3_pulse | dir_ff[B_P6];
  wire logic drv5 = sel_w | dir_ff[B_P5];
  wire logic val7 = data_ff[B_P7];
  wire logic val6 = sel_ta3_pulse ? ta3_pulse_i : data_ff[B_P6];
  wire logic val5 = sel_w ? w_phase_i : data_ff[B_P5];
  wire logic pull7 = ~dir_ff[B_P7] & pull_grp;
  wire logic pull6 = ~dir_ff[B_P6] & pull_grp;
  wire logic pull5 = ~dir_ff[B_P5] & pull_grp;

  logic lvl7;
  logic lvl6;
  logic lvl5;

  // Reading the data register shows the pad for inputs and the latch for
  // outputs, even while a timer also takes the input.
  wire logic [2:0] lvl_up = {lvl7, lvl6, lvl5};
  wire logic [2:0] dir_up = dir_ff[B_P7:B_P5];
  wire logic [2:0] lat_up = data_ff[B_P7:B_P5];
  wire logic [2:0] view_up = (dir_up & lat_up) | (~dir_up & lvl_up);
  wire logic [REG_W-1:0] port_view = {view_up, data_ff[B_P5-1:0]};
  wire logic [REG_W-1:0] status = {2'b00, sel_w, sel_ta2_in, sel_ta3_pulse, sel_ta3_2ph,
                                   sel_ta3_ud, sel_ta3_in};

  wire logic [REG_W-1:0] rd_byte =
      hit_dir ? dir_ff :
      hit_pull ? pull_ff :
      hit_trig ? trig_ff :
      hit_ta3 ? ta3_mode_ff :
      hit_ta2 ? ta2_mode_ff :
      hit_updn ? updn_ff :
      hit_tph ? tph_ff :
      hit_data ? port_view :
      hit_stat ? status : RST_REG;
  wire logic [DAT_W-1:0] nxt_rdat = {{(DAT_W-REG_W){1'b0}}, rd_byte};

  // -----------------------------------------------------------------------
  // Register writes
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dir_ff <= RST_REG;
      pull_ff <= RST_REG;
      trig_ff <= RST_REG;
      ta3_mode_ff <= RST_REG;
      ta2_mode_ff <= RST_REG;
    end else if (ce_i && wr_go) begin
      if (hit_dir) dir_ff <= wbyte;
      if (hit_pull) pull_ff <= wbyte;
      if (hit_trig) trig_ff <= wbyte;
      if (hit_ta3) ta3_mode_ff <= wbyte;
      if (hit_ta2) ta2_mode_ff <= wbyte;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      updn_ff <= RST_REG;
      tph_ff <= RST_REG;
      data_ff <= RST_REG;
    end else if (ce_i && wr_go) begin
      if (hit_updn) updn_ff <= wbyte;
      if (hit_tph) tph_ff <= wbyte;
      if (hit_data) data_ff <= wbyte;
    end
  end

  // -----------------------------------------------------------------------
  // Bus answer
  // -----------------------------------------------------------------------
  // Every access, mapped or not, is answered one cycle after it is seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= RD_ZERO;
    end else if (ce_i) begin
      ack_ff <= req;
      if (req && !wb_we_i) rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  // -----------------------------------------------------------------------
  // Timer side
  // -----------------------------------------------------------------------
  logic ta3_in_ff;
  logic ta3_ud_ff;
  logic ta3_2ph_ff;
  logic ta2_in_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ta3_in_ff <= 1'b0;
      ta3_ud_ff <= 1'b0;
      ta3_2ph_ff <= 1'b0;
      ta2_in_ff <= 1'b0;
    end else if (ce_i) begin
      ta3_in_ff <= sel_ta3_in & lvl7;
      ta3_ud_ff <= sel_ta3_ud & lvl6;
      ta3_2ph_ff <= sel_ta3_2ph & lvl6;
      ta2_in_ff <= sel_ta2_in & lvl5;
    end
  end

  assign timer3_input_pin_o = ta3_in_ff;
  assign ta3_updown_o = ta3_ud_ff;
  assign ta3_twophase_o = ta3_2ph_ff;
  assign timer2_input_pin_o = ta2_in_ff;
  // Gate and external trigger use need mode bit 4; count source does not.
  assign ta3_gate_mode_o = ta3_mode_ff[B_MODE_GATE];
  assign ta2_gate_mode_o = ta2_mode_ff[B_MODE_GATE];

  // -----------------------------------------------------------------------
  // Pads
  // -----------------------------------------------------------------------
  p7pf_pin u_pin7 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .drive_en_i(drv7),
    .drive_val_i(val7),
    .pull_req_i(pull7),
    .pad_i(port7_bit7_pin_i),
    .pad_o(port7_bit7_pin_o),
    .pad_oe_n_o(port7_bit7_pin_oe_n_o),
    .pull_up_o(port7_bit7_pull_up_o),
    .level_o(lvl7)
  );

  p7pf_pin u_pin6 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .drive_en_i(drv6),
    .drive_val_i(val6),
    .pull_req_i(pull6),
    .pad_i(port7_bit6_pin_i),
    .pad_o(port7_bit6_pin_o),
    .pad_oe_n_o(port7_bit6_pin_oe_n_o),
    .pull_up_o(port7_bit6_pull_up_o),
    .level_o(lvl6)
  );

  p7pf_pin u_pin5 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .drive_en_i(drv5),
    .drive_val_i(val5),
    .pull_req_i(pull5),
    .pad_i(port7_bit5_pin_i),
    .pad_o(port7_bit5_pin_o),
    .pad_oe_n_o(port7_bit5_pin_oe_n_o),
    .pull_up_o(port7_bit5_pull_up_o),
    .level_o(lvl5)
  );

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_data_read;
    ce_i && req && !wb_we_i && hit_data;
  endsequence

  sequence s_ack_with_view;
    wb_ack_o && wb_dat_o[B_P7:B_P5] == $past(view_up);
  endsequence

  a_ta3_in_route: assert property (ce_i && !dir_ff[B_P7] && trig_ta3_clr |=>
      timer3_input_pin_o == $past(lvl7))
    else $error("timer 3 input does not follow bit 7");
  a_ta2_in_block: assert property (ce_i && tph_on |=> !timer2_input_pin_o)
    else $error("timer 2 input active in three-phase mode");
  a_ta3_updown: assert property (ce_i && !dir_ff[B_P6] && ta3_gate && !ta3_pulse_mode
      && !ta3_2ph |=> ta3_updown_o == $past(lvl6) && !ta3_twophase_o)
    else $error("up/down input not routed");
  a_ta3_twophase: assert property (ce_i && !dir_ff[B_P6] && ta3_gate && !ta3_pulse_mode
      && ta3_2ph |=> ta3_twophase_o == $past(lvl6) && !ta3_updown_o)
    else $error("two-phase input not routed");
  a_dir_output: assert property (ce_i && dir_ff[B_P7] |=>
      !port7_bit7_pin_oe_n_o && port7_bit7_pin_o == $past(data_ff[B_P7]))
    else $error("bit 7 output not driven from latch");
  a_input_pull: assert property (ce_i && !dir_ff[B_P7] |=>
      port7_bit7_pin_oe_n_o && port7_bit7_pull_up_o == $past(pull_grp))
    else $error("bit 7 input pull-up wrong");
  a_w_phase: assert property (ce_i && tph_on |=>
      !port7_bit5_pin_oe_n_o && port7_bit5_pin_o == $past(w_phase_i))
    else $error("W phase not on bit 5");
  a_pulse_out: assert property (ce_i && ta3_pulse_mode && !ta3_2ph |=>
      !port7_bit6_pin_oe_n_o && port7_bit6_pin_o == $past(ta3_pulse_i))
    else $error("pulse output not on bit 6");
  a_pulse_blocked: assert property (ce_i && ta3_pulse_mode && ta3_2ph && !dir_ff[B_P6] |=>
      port7_bit6_pin_oe_n_o)
    else $error("pulse output during two-phase");
  a_port_read: assert property (s_data_read |=> s_ack_with_view)
    else $error("port read misses pin level");
endmodule : p7pf_top

// [hdl/p7pf_pkg.sv]
/*
 * Constants for the port 7 upper pin function select block: register indices,
 * field positions, reset values and Wishbone geometry.
 * Assumes a 32-bit classic Wishbone bus with byte addresses; a register's
 * byte address is four times its index.
 */
package p7pf_pkg;
  // ---------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------
  localparam int ADR_W = 12;
  localparam int IDX_W = 10;
  localparam int DAT_W = 32;
  localparam int REG_W = 8;

  // ---------------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_DIR = 10'h3EF;
  localparam logic [IDX_W-1:0] IDX_PULL = 10'h3FD;
  localparam logic [IDX_W-1:0] IDX_TRIG = 10'h383;
  localparam logic [IDX_W-1:0] IDX_TA3_MODE = 10'h399;
  localparam logic [IDX_W-1:0] IDX_TA2_MODE = 10'h398;
  localparam logic [IDX_W-1:0] IDX_UPDN = 10'h384;
  localparam logic [IDX_W-1:0] IDX_TPH = 10'h348;
  localparam logic [IDX_W-1:0] IDX_DATA = 10'h3ED;
  localparam logic [IDX_W-1:0] IDX_STAT = 10'h3EC;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int B_P7 = 7;
  localparam int B_P6 = 6;
  localparam int B_P5 = 5;
  localparam int B_PULL_P74_77 = 7;
  localparam int B_TRIG_TA3_HI = 5;
  localparam int B_TRIG_TA3_LO = 4;
  localparam int B_TRIG_TA2_HI = 3;
  localparam int B_TRIG_TA2_LO = 2;
  localparam int B_MODE_GATE = 4;
  localparam int B_MODE_PULSE = 2;
  localparam int B_UPDN_TA3_2PH = 6;
  localparam int B_TPH_ENABLE = 2;
  localparam int B_ST_TA3_IN = 0;
  localparam int B_ST_TA3_UD = 1;
  localparam int B_ST_TA3_2PH = 2;
  localparam int B_ST_TA3_PULSE = 3;
  localparam int B_ST_TA2_IN = 4;
  localparam int B_ST_W_PHASE = 5;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [REG_W-1:0] RST_REG = 8'h00;
  localparam logic [DAT_W-1:0] RD_ZERO = 32'h00000000;
endpackage : p7pf_pkg

// [hdl/p7pf_pin.sv]
/*
 * One multiplexed pad: registers the drive enable, drive value and pull-up
 * request, and samples the pad level.
 * Assumes the pad input is synchronous to clk_i and that the surroundings
 * resolve the wire from the active-low output enable.
 */
`timescale 1ns/1ns
module p7pf_pin (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic drive_en_i,
  input wire logic drive_val_i,
  input wire logic pull_req_i,
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_n_o,
  output logic pull_up_o,
  output logic level_o
);
  import p7pf_pkg::*;

  logic out_ff;
  logic oe_n_ff;
  logic pull_ff;
  logic lvl_ff;
  wire logic nxt_oe_n = ~drive_en_i;
  wire logic nxt_pull = pull_req_i & ~drive_en_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      pull_ff <= 1'b0;
      lvl_ff <= 1'b0;
    end else if (ce_i) begin
      out_ff <= drive_val_i;
      oe_n_ff <= nxt_oe_n;
      pull_ff <= nxt_pull;
      lvl_ff <= pad_i;
    end
  end

  assign pad_o = out_ff;
  assign pad_oe_n_o = oe_n_ff;
  assign pull_up_o = pull_ff;
  assign level_o = lvl_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // A driven pad never has its pull-up on.
  a_pull_off_drive: assert property (ce_i && drive_en_i |=> !pull_up_o && !pad_oe_n_o)
    else $error("pull-up left on while pad driven");
endmodule : p7pf_pin

// [verification/p7pf_partner.sv]
/*
 * Stand-in for the timer A3 pulse output and the three-phase W phase output.
 * Assumes the bench strobes step_i between configurations.
 */
`timescale 1ns/1ns
module p7pf_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  output logic ta3_pulse_o,
  output logic w_phase_o
);
  logic [7:0] lfsr_ff;
  // Values move only on a step, because the port data read samples the pads.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lfsr_ff <= 8'h5A;
    end else if (step_i) begin
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
    end
  end
  assign ta3_pulse_o = lfsr_ff[0];
  assign w_phase_o = lfsr_ff[2];
endmodule : p7pf_partner

// [verification/tb_top.sv]
/*
 * Self-checking bench for the port 7 upper pin function select block.
 * Assumes pads are resolved here: a released pad follows the bench's drive.
 */
`timescale 1ns/1ns
module tb_top;
  import p7pf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [DAT_W-1:0] wdat = '0;
  logic [DAT_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic [2:0] ext = 3'h0;
  logic step = 1'b0;
  wire logic [2:0] po, oe, pu, pad;
  logic pulse, wph, t3in, ud, tw, t2in, g3, g2;
  logic [7:0] val [8];
  logic [IDX_W-1:0] idx_tab [8];
  int n_errors = 0;
  int cmp_count = 0;
  assign pad = (oe & ext) | (~oe & po);
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  p7pf_partner prt (.clk_i(clk_i), .rst_i(rst_i), .step_i(step), .ta3_pulse_o(pulse),
    .w_phase_o(wph));
  p7pf_top uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .port7_bit7_pin_i(pad[2]), .port7_bit7_pin_o(po[2]),
    .port7_bit7_pin_oe_n_o(oe[2]), .port7_bit7_pull_up_o(pu[2]),
    .port7_bit6_pin_i(pad[1]), .port7_bit6_pin_o(po[1]),
    .port7_bit6_pin_oe_n_o(oe[1]), .port7_bit6_pull_up_o(pu[1]),
    .port7_bit5_pin_i(pad[0]), .port7_bit5_pin_o(po[0]),
    .port7_bit5_pin_oe_n_o(oe[0]), .port7_bit5_pull_up_o(pu[0]),
    .ta3_pulse_i(pulse), .w_phase_i(wph), .timer3_input_pin_o(t3in), .ta3_updown_o(ud),
    .ta3_twophase_o(tw), .timer2_input_pin_o(t2in), .ta3_gate_mode_o(g3),
    .ta2_gate_mode_o(g2));
  // ---------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  // The request is held until ack is sampled high; read data is taken there.
  task automatic wb(input logic [IDX_W-1:0] idx, input logic w, input logic [3:0] s,
      input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= s;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
    end
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  // Behavioural model of the selection, compared with every pad and timer output.
  task automatic check_all();
    logic [31:0] q;
    logic [5:0] s;
    logic [2:0] drv, v, lvl, d;
    logic tpm, pls, gt3;
    d = val[0][7:5];
    tpm = val[6][B_TPH_ENABLE];
    pls = val[3][B_MODE_PULSE] & !val[5][B_UPDN_TA3_2PH];
    gt3 = !d[1] & val[3][B_MODE_GATE] & !val[3][B_MODE_PULSE];
    drv = {d[2], pls | d[1], tpm | d[0]};
    v = {val[7][7], pls ? pulse : val[7][6], tpm ? wph : val[7][5]};
    lvl = (drv & v) | (~drv & ext);
    s[0] = !d[2] && val[2][5:4] == 2'b00;
    s[1] = gt3 & !val[5][B_UPDN_TA3_2PH];
    s[2] = gt3 & val[5][B_UPDN_TA3_2PH];
    s[3] = pls;
    s[4] = !d[0] && val[2][3:2] == 2'b00 && !tpm;
    s[5] = tpm;
    chk("oe_n", {29'h0, oe}, {29'h0, ~drv});
    chk("pin_o", {29'h0, po & drv}, {29'h0, v & drv});
    chk("pull_up", {29'h0, pu}, {29'h0, {3{val[1][7]}} & ~drv});
    chk("timer_in", {28'h0, t3in, ud, tw, t2in},
      {28'h0, s[0] & lvl[2], s[1] & lvl[1], s[2] & lvl[1], s[4] & lvl[0]});
    chk("gate", {30'h0, g3, g2}, {30'h0, val[3][4], val[4][4]});
    wb(IDX_STAT, 1'b0, 4'hF, 8'h00, q);
    chk("status", q, {26'h0, s});
    wb(IDX_DATA, 1'b0, 4'hF, 8'h00, q);
    chk("data", q, {24'h0, (val[7][7:5] & d) | (lvl & ~d), val[7][4:0]});
  endtask : check_all
  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    logic [31:0] q;
    idx_tab = '{IDX_DIR, IDX_PULL, IDX_TRIG, IDX_TA3_MODE, IDX_TA2_MODE, IDX_UPDN, IDX_TPH,
      IDX_DATA};
    void'($urandom(12));
    repeat (8) @(posedge clk_i);
    chk("oe_reset", {29'h0, oe}, 32'h7);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      val[i] = 8'h00;
    end
    for (int i = 0; i < 7; i++) begin
      wb(idx_tab[i], 1'b0, 4'hF, 8'h00, q);
      chk("reset_reg", q, RD_ZERO);
    end
    wb(10'h000, 1'b0, 4'hF, 8'h00, q);
    chk("unmapped", q, RD_ZERO);
    for (int it = 0; it < 200; it++) begin
      @(posedge clk_i);
      step <= 1'b1;
      ext <= 3'($urandom);
      @(posedge clk_i);
      step <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        val[i] = 8'($urandom);
        wb(idx_tab[i], 1'b1, 4'hF, val[i], q);
      end
      repeat (5) @(posedge clk_i);
      check_all();
    end
    wb(IDX_DIR, 1'b1, 4'hE, ~val[0], q);
    wb(IDX_DIR, 1'b0, 4'hF, 8'h00, q);
    chk("sel_gate", q, {24'h0, val[0]});
    results();
  end
  initial begin
    repeat (40000) @(posedge clk_i);
    n_errors++;
    results();
  end
endmodule : tb_top
